/* File: rtl/slc_crc_step.sv */
// Purpose: One serial step of a configurable 16-bit division register
// Assumes: Combinational; caller registers the result
// Notes:   Taps chosen per mode, shared by transmit and receive
`timescale 1ns/1ns
module slc_crc_step
  import slcrc_pkg::*;
(
  input  wire logic             bitMode,
  input  wire logic [CRC_W-1:0] crcIn,
  input  wire logic             dataIn,
  output logic      [CRC_W-1:0] crcOut
);

  logic             fb;
  logic [CRC_W-1:0] poly;

  always_comb begin
    fb     = crcIn[CRC_W-1] ^ dataIn;
    poly   = bitMode ? POLY_CCITT : POLY_CRC16;
    crcOut = {crcIn[CRC_W-2:0], 1'b0} ^ (fb ? poly : '0);
  end

endmodule : slc_crc_step

/* File: rtl/slc_line_crc.sv */
// Purpose: Transmit and receive check logic of a synchronous line unit
// Assumes: One bit per valid strobe on each path, same clock as the bus
// Notes:   Message end is judged by software, not counted here
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module slc_line_crc
  import slcrc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [3:0]    regAddr,
  input  wire logic [31:0]   regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [31:0]   regRdata,
  input  wire slc_tx_bit_t   txIn,
  output logic               txReady,
  output slc_line_bit_t      txLine,
  input  wire slc_rx_bit_t   rxIn,
  output logic               matchFlag,
  output logic               irq
);

  // ==========================================================
  // Register file
  // ==========================================================
  logic [1:0]     ctrl_reg;
  logic [1:0]     ctrl_next;
  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] status_next;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] mask_next;
  logic [31:0]    rdata_reg;
  logic [31:0]    rdata_next;
  logic           irq_reg;
  logic           irq_next;
  logic [EV_W-1:0] events;

  logic bitMode;
  logic strapFit;
  assign bitMode  = ctrl_reg[CTRL_MODE_BIT];
  assign strapFit = ctrl_reg[CTRL_STRAP_BIT];

  // ==========================================================
  // Transmit path
  // ==========================================================
  slc_tx_state_t    txState_reg;
  slc_tx_state_t    txState_next;
  logic [CRC_W-1:0] txCrc_reg;
  logic [CRC_W-1:0] txCrc_next;
  logic [CRC_W-1:0] txStep;
  logic [CRC_W-1:0] txWord;
  logic             txLoad;
  logic             txShift;
  logic             serBit;
  logic             serLast;
  slc_line_bit_t    txLine_reg;
  slc_line_bit_t    txLine_next;
  logic             txReady_reg;
  logic             txReady_next;
  logic             txDoneEv;

  function automatic logic [CRC_W-1:0] presetFor(input logic bm);
    presetFor = bm ? PRESET_BIT : PRESET_BYTE;
  endfunction : presetFor

  slc_crc_step u_tx_step (
    .bitMode (bitMode),
    .crcIn   (txCrc_reg),
    .dataIn  (txIn.data),
    .crcOut  (txStep)
  );

  // Built from the stepped value so the end-tagged bit is covered
  always_comb begin
    txWord = txStep;
    if (bitMode) begin
      txWord = ~txWord;
    end
    if (!strapFit) begin
      txWord = ~txWord;
    end
  end

  slc_tx_serial u_tx_ser (
    .clk    (clk),
    .srst   (srst),
    .load   (txLoad),
    .word   (txWord),
    .shift  (txShift),
    .outBit (serBit),
    .last   (serLast)
  );

  always_comb begin
    txState_next = txState_reg;
    txCrc_next   = txCrc_reg;
    txLine_next  = '0;
    txReady_next = 1'b1;
    txLoad       = 1'b0;
    txShift      = 1'b0;
    txDoneEv     = 1'b0;
    case (txState_reg)
      SLC_TX_IDLE, SLC_TX_DATA: begin
        if (txIn.valid && txReady_reg) begin
          txLine_next.valid = 1'b1;
          txLine_next.data  = txIn.data;
          if (txIn.startTag) begin
            txCrc_next   = presetFor(bitMode);
            txState_next = SLC_TX_IDLE;
          end else begin
            txCrc_next   = txStep;
            txState_next = SLC_TX_DATA;
          end
          if (txIn.endTag && !txIn.startTag) begin
            txLoad       = 1'b1;
            txState_next = SLC_TX_CHECK;
            txReady_next = 1'b0;
          end
        end
      end
      SLC_TX_CHECK: begin
        txReady_next      = 1'b0;
        txShift           = 1'b1;
        txLine_next.valid = 1'b1;
        txLine_next.data  = serBit;
        if (serLast) begin
          txCrc_next   = presetFor(bitMode);
          txState_next = SLC_TX_IDLE;
          txReady_next = 1'b1;
          txDoneEv     = 1'b1;
        end
      end
      default: begin
        txState_next = SLC_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      txState_reg <= SLC_TX_IDLE;
      txCrc_reg   <= PRESET_BYTE;
      txLine_reg  <= '0;
      txReady_reg <= 1'b1;
    end else begin
      txState_reg <= txState_next;
      txCrc_reg   <= txCrc_next;
      txLine_reg  <= txLine_next;
      txReady_reg <= txReady_next;
    end
  end

  assign txLine  = txLine_reg;
  assign txReady = txReady_reg;

  // ==========================================================
  // Receive path
  // ==========================================================
  logic [CRC_W-1:0] rxCrc_reg;
  logic [CRC_W-1:0] rxCrc_next;
  logic [CRC_W-1:0] rxStep;
  logic [CRC_W-1:0] rxSeed;
  logic             match_reg;
  logic             match_next;
  logic             matchEv;

  always_comb begin
    rxSeed = presetFor(bitMode);
  end

  slc_crc_step u_rx_step (
    .bitMode (bitMode),
    .crcIn   (rxIn.frameStart ? rxSeed : rxCrc_reg),
    .dataIn  (rxIn.data),
    .crcOut  (rxStep)
  );

  // Only a good/bad verdict; no count or location, software picks the end
  always_comb begin
    rxCrc_next = rxCrc_reg;
    if (rxIn.valid) begin
      rxCrc_next = rxStep;
    end else if (rxIn.frameStart) begin
      rxCrc_next = rxSeed;
    end
    // Mode of the coming cycle, so a mode write never leaves a stale flag
    match_next = ctrl_next[CTRL_MODE_BIT] ? (rxCrc_next == RESIDUE_BIT)
                                          : (rxCrc_next == RESIDUE_BYTE);
    matchEv = match_next && !match_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxCrc_reg <= PRESET_BYTE;
      match_reg <= 1'b1;
    end else begin
      rxCrc_reg <= rxCrc_next;
      match_reg <= match_next;
    end
  end

  assign matchFlag = match_reg;

  // ==========================================================
  // Bus slave and interrupt
  // ==========================================================
  always_comb begin
    events                = '0;
    events[EV_MATCH]      = matchEv;
    events[EV_TXDONE]     = txDoneEv;
    ctrl_next             = ctrl_reg;
    mask_next             = mask_reg;
    status_next           = status_reg;
    rdata_next            = '0;
    if (regWr && regAddr == ADDR_CTRL) begin
      ctrl_next = regWdata[1:0];
    end
    if (regWr && regAddr == ADDR_MASK) begin
      mask_next = regWdata[EV_W-1:0];
    end
    if (regRd) begin
      case (regAddr)
        ADDR_CTRL:   rdata_next = {30'h0, ctrl_reg};
        ADDR_STATUS: begin
          rdata_next  = {30'h0, status_reg};
          status_next = '0;
        end
        ADDR_MASK:   rdata_next = {30'h0, mask_reg};
        ADDR_TXCHK:  rdata_next = {16'h0, txCrc_reg};
        default:     rdata_next = '0;
      endcase
    end
    // Set beats clear so no event is lost in the reading cycle
    status_next = status_next | events;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg   <= CTRL_RESET;
      mask_reg   <= MASK_RESET;
      status_reg <= '0;
      rdata_reg  <= '0;
      irq_reg    <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      mask_reg   <= mask_next;
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
      irq_reg    <= irq_next;
    end
  end

  assign regRdata = rdata_reg;
  assign irq      = irq_reg;

  // ==========================================================
  // Assertion helpers
  // ==========================================================
  // A counter stands in for a long repeat, which would unroll badly
  logic [4:0] chkLen_reg;
  logic [4:0] chkLen_next;

  always_comb begin
    chkLen_next = 5'h00;
    if (txState_reg == SLC_TX_CHECK) begin
      chkLen_next = chkLen_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chkLen_reg <= 5'h00;
    end else begin
      chkLen_reg <= chkLen_next;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  byte_match_a: assert property (@(posedge clk) disable iff (srst)
    !bitMode |-> (matchFlag == (rxCrc_reg == RESIDUE_BYTE)))
    else $error("byte mode match flag wrong");

  bit_match_a: assert property (@(posedge clk) disable iff (srst)
    bitMode |-> (matchFlag == (rxCrc_reg == RESIDUE_BIT)))
    else $error("bit mode match flag wrong");

  rx_hold_a: assert property (@(posedge clk) disable iff (srst)
    !rxIn.valid && !rxIn.frameStart |=> $stable(rxCrc_reg))
    else $error("receive register moved without a bit");

  rx_preset_a: assert property (@(posedge clk) disable iff (srst)
    bitMode && rxIn.frameStart && !rxIn.valid |=> rxCrc_reg == PRESET_BIT)
    else $error("receive preset not all ones");

  tx_tag_preset_a: assert property (@(posedge clk) disable iff (srst)
    txIn.valid && txReady && txIn.startTag && !txIn.endTag
      |=> txCrc_reg == (bitMode ? PRESET_BIT : PRESET_BYTE))
    else $error("start tag did not preset");

  tx_check_len_a: assert property (@(posedge clk) disable iff (srst)
    txLoad |-> ##17 (txState_reg == SLC_TX_IDLE && chkLen_reg == 5'h10))
    else $error("check word not sixteen bits");

  tx_check_cap_a: assert property (@(posedge clk) disable iff (srst)
    txState_reg == SLC_TX_CHECK |-> chkLen_reg < 5'h10)
    else $error("check word longer than sixteen bits");

  tx_first_bit_a: assert property (@(posedge clk) disable iff (srst)
    txLoad && $stable(ctrl_reg) |=> ##1
      txLine.data == ($past(txCrc_reg[CRC_W-1]) ^ bitMode ^ !strapFit))
    else $error("check word polarity wrong");

  tx_stall_a: assert property (@(posedge clk) disable iff (srst)
    txState_reg == SLC_TX_CHECK |-> !txReady)
    else $error("ready high while sending check");

  irq_a: assert property (@(posedge clk) disable iff (srst)
    irq == |(status_reg & mask_reg))
    else $error("interrupt level wrong");

  cov_tx_c: cover property (@(posedge clk) disable iff (srst) txDoneEv);
  cov_match_c: cover property (@(posedge clk) disable iff (srst) bitMode && matchEv);
  cov_byte_c: cover property (@(posedge clk) disable iff (srst) !bitMode && matchEv);
  cov_irq_c: cover property (@(posedge clk) disable iff (srst) irq);

endmodule : slc_line_crc

/* File: rtl/slc_tx_serial.sv */
// Purpose: Shift-out of the transmit check word
// Assumes: Loaded once, shifted one bit per enable
// Notes:   Most significant bit goes first on the line
`timescale 1ns/1ns
module slc_tx_serial
  import slcrc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             load,
  input  wire logic [CRC_W-1:0] word,
  input  wire logic             shift,
  output logic                  outBit,
  output logic                  last
);

  logic [CRC_W-1:0] sh_reg;
  logic [CRC_W-1:0] sh_next;
  logic [4:0]       cnt_reg;
  logic [4:0]       cnt_next;

  always_comb begin
    sh_next  = sh_reg;
    cnt_next = cnt_reg;
    if (load) begin
      sh_next  = word;
      cnt_next = 5'h0;
    end else if (shift) begin
      sh_next  = {sh_reg[CRC_W-2:0], 1'b0};
      cnt_next = cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sh_reg  <= '0;
      cnt_reg <= 5'h0;
    end else begin
      sh_reg  <= sh_next;
      cnt_reg <= cnt_next;
    end
  end

  assign outBit = sh_reg[CRC_W-1];
  assign last   = (cnt_reg == 5'(CRC_W - 1));

endmodule : slc_tx_serial

/* File: rtl/slcrc_pkg.sv */
// Purpose: Shared constants and types of the line check unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Polynomials are written with the x^16 term implied
package slcrc_pkg;

  localparam int unsigned CRC_W = 16;

  // Feedback taps, x^16 implied
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_CRC16 = 16'h8005;

  // Presets per mode
  localparam logic [15:0] PRESET_BYTE = 16'h0000;
  localparam logic [15:0] PRESET_BIT  = 16'hFFFF;

  // Receive residues
  localparam logic [15:0] RESIDUE_BYTE = 16'h0000;
  localparam logic [15:0] RESIDUE_BIT  = 16'h1D0F;

  // Register offsets (byte addresses)
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK   = 4'h8;
  localparam logic [3:0] ADDR_TXCHK  = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_MODE_BIT  = 0;
  localparam int unsigned CTRL_STRAP_BIT = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h2;

  // Status / mask fields
  localparam int unsigned EV_MATCH  = 0;
  localparam int unsigned EV_TXDONE = 1;
  localparam int unsigned EV_W      = 2;
  localparam logic [1:0]  MASK_RESET = 2'h0;

  typedef enum logic [2:0] {
    SLC_TX_IDLE  = 3'b001,
    SLC_TX_DATA  = 3'b010,
    SLC_TX_CHECK = 3'b100
  } slc_tx_state_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic startTag;
    logic endTag;
  } slc_tx_bit_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic frameStart;
  } slc_rx_bit_t;

  typedef struct packed {
    logic valid;
    logic data;
  } slc_line_bit_t;

endpackage : slcrc_pkg

/* File: tb/slc_line_crc_test.sv */
// Purpose: Self-checking bench of the line check unit
// Assumes: Far-side model loops the line back into the receiver
// Notes:   Four mode/strap settings share one message
`timescale 1ns/1ns
module slc_line_crc_test;
  import slcrc_pkg::*;
  logic          clk;
  logic          srst;
  logic [3:0]    regAddr;
  logic [31:0]   regWdata;
  logic          regWr;
  logic          regRd;
  logic [31:0]   regRdata;
  slc_tx_bit_t   txIn;
  logic          txReady;
  slc_line_bit_t txLine;
  slc_rx_bit_t   rxIn;
  logic          matchFlag;
  logic          irq;
  logic          armFrame;
  int            miscompares;
  int            comparisons;
  int            cycles;
  logic          lineQ[$];

  slc_line_crc u_dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txIn(txIn), .txReady(txReady),
    .txLine(txLine), .rxIn(rxIn), .matchFlag(matchFlag), .irq(irq));
  slcrc_far_end u_far (.clk(clk), .srst(srst), .armFrame(armFrame), .txLine(txLine),
    .rxIn(rxIn));

  // ==========================================================
  // Clock, line capture, timeout
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (txLine.valid === 1'b1) lineQ.push_back(txLine.data);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask : reg_rd

  // Called just after an edge; returns just after the accepting edge
  task automatic send_bit(input logic d, input logic st, input logic et);
    int n;
    n = 0;
    txIn <= '{1'b1, d, st, et};
    do begin
      @(negedge clk);
      n++;
    end while (txReady !== 1'b1 && n < 100);
    if (txReady !== 1'b1) chk("tx ready", 48'h1, {47'h0, txReady});
    @(posedge clk);
  endtask : send_bit

  function automatic logic [15:0] ref_crc(input logic bitMode, input logic [23:0] msg);
    logic [15:0] c;
    logic        fb;
    c = bitMode ? 16'hFFFF : 16'h0000;
    for (int i = 23; i >= 0; i--) begin
      fb = c[15] ^ msg[i];
      c  = {c[14:0], 1'b0} ^ (fb ? (bitMode ? 16'h1021 : 16'h8005) : 16'h0000);
    end
    return c;
  endfunction : ref_crc

  // ==========================================================
  // Scenarios
  task automatic reset_regs();
    logic [31:0] d;
    chk("match after reset", 48'h1, {47'h0, matchFlag});
    reg_rd(ADDR_CTRL, d);
    chk("ctrl reset", 48'h2, {16'h0, d});
    reg_wr(4'h2, 32'h0000_0001);
    reg_rd(4'h2, d);
    chk("unmapped read", 48'h0, {16'h0, d});
    reg_rd(ADDR_CTRL, d);
    chk("ctrl after unmapped write", 48'h2, {16'h0, d});
    reg_rd(ADDR_MASK, d);
    chk("mask reset", 48'h0, {16'h0, d});
  endtask : reset_regs

  // Start-tagged flag byte, then 24 counted bits, last one end-tagged
  task automatic run_msg(input logic [1:0] ctrl);
    logic [23:0] msg;
    logic [15:0] word;
    logic [47:0] got;
    int          n;
    logic [31:0] d;
    logic [7:0]  flag;
    msg  = 24'hA5C3_3C;
    flag = 8'h7E;
    word = ref_crc(ctrl[0], msg) ^ (ctrl[0] ? 16'hFFFF : 16'h0)
           ^ (ctrl[1] ? 16'h0 : 16'hFFFF);
    reg_wr(ADDR_CTRL, {30'h0, ctrl});
    lineQ.delete();
    @(posedge clk);
    for (int i = 7; i >= 0; i--) send_bit(flag[i], 1'b1, 1'b0);
    txIn     <= '0;
    @(posedge clk);
    armFrame <= 1'b1;
    @(posedge clk);
    armFrame <= 1'b0;
    for (int i = 23; i >= 0; i--) send_bit(msg[i], 1'b0, i == 0);
    txIn <= '0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (txReady !== 1'b1 && n < 40);
    chk("check word cycles", 48'h11, 48'(n));
    repeat (3) @(negedge clk);
    got = '0;
    foreach (lineQ[i]) got = {got[46:0], lineQ[i]};
    chk("line bit count", 48'h30, 48'(lineQ.size()));
    chk("line stream", {8'h7E, msg, word}, got);
    chk("match flag", {47'h0, ctrl[1]}, {47'h0, matchFlag});
    reg_rd(ADDR_TXCHK, d);
    chk("tx register re-preset", ctrl[0] ? 48'hFFFF : 48'h0, {16'h0, d});
  endtask : run_msg

  task automatic irq_flow();
    logic [31:0] d;
    reg_rd(ADDR_STATUS, d);
    reg_wr(ADDR_MASK, 32'h0000_0003);
    run_msg(2'h2);
    chk("irq raised", 48'h1, {47'h0, irq});
    reg_rd(ADDR_STATUS, d);
    chk("status events", 48'h3, {16'h0, d});
    @(negedge clk);
    chk("irq cleared", 48'h0, {47'h0, irq});
    reg_wr(ADDR_MASK, 32'h0000_0000);
    run_msg(2'h2);
    chk("irq masked", 48'h0, {47'h0, irq});
  endtask : irq_flow

  task automatic stop_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // Main sequence
  initial begin
    srst        = 1'b1;
    regAddr     = '0;
    regWdata    = '0;
    regWr       = 1'b0;
    regRd       = 1'b0;
    txIn        = '0;
    armFrame    = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    reset_regs();
    irq_flow();
    // Bit fitted, byte absent, bit absent, byte fitted
    run_msg(2'h3);
    run_msg(2'h0);
    run_msg(2'h1);
    run_msg(2'h2);
    stop_test();
  end
endmodule : slc_line_crc_test

/* File: tb/slcrc_far_end.sv */
// Purpose: Far-side model, serializer looped back into the deserializer
// Assumes: Line bits arrive one per valid cycle on the unit clock
// Notes:   armFrame, sampled with the line idle, marks the next line bit as the first of a frame
`timescale 1ns/1ns
module slcrc_far_end
  import slcrc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          armFrame,
  input  wire slc_line_bit_t txLine,
  output slc_rx_bit_t        rxIn
);
  // ==========================================================
  // Frame marker and idle line
  logic armReg;
  logic lastReg;

  always_ff @(posedge clk) begin
    if (srst) begin
      armReg  <= 1'b0;
      lastReg <= 1'b0;
    end else begin
      if (txLine.valid) armReg <= 1'b0;
      else if (armFrame) armReg <= 1'b1;
      if (txLine.valid) lastReg <= txLine.data;
    end
  end

  // Idle line shows the inverse of the last bit, never a stale copy
  assign rxIn.valid      = txLine.valid;
  assign rxIn.data       = txLine.valid ? txLine.data : ~lastReg;
  // Marker stands before the first bit as well, so a bare preset occurs
  assign rxIn.frameStart = armReg;
endmodule : slcrc_far_end
